// ===== hdl/ssc_counter.v
// one 32-bit statistics counter with clear and saturation
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.vh"

module ssc_counter (
    input wire clk,                  // 40 mhz clock
    input wire srst,                 // synchronous reset, active high
    input wire clr,                  // clear, restarting from this cycle's inc
    input wire [13:0] inc,           // amount to add this cycle
    output reg [31:0] count          // current value
);

    wire [32:0] sum;

    assign sum = {1'b0, count} + {19'h0_0000, inc};

    // ==========================================================
    // update
    always @(posedge clk) begin
        if (srst) begin
            count <= `SSC_CNT_ZERO;
        end else if (clr) begin
            // an event in the clear cycle is kept, not lost
            count <= {18'h0_0000, inc};
        end else if (sum[32]) begin
            count <= `SSC_CNT_ONES; // saturate rather than wrap
        end else begin
            count <= sum[31:0];
        end
    end

endmodule
`default_nettype wire

// ===== hdl/ssc_defines.vh
// constants shared by the sideband statistics counter block
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// ==========================================================
// widths
`define SSC_CNT_W 32
`define SSC_LEN_W 14
`define SSC_CNT_ZERO 32'h0000_0000
`define SSC_CNT_ONES 32'hFFFF_FFFF

// ==========================================================
// frame size bins, destination address through fcs
`define SSC_LEN_MIN 14'h0040
`define SSC_BIN0_LO 14'h0041
`define SSC_BIN0_HI 14'h007F
`define SSC_BIN1_LO 14'h0080
`define SSC_BIN1_HI 14'h00FF
`define SSC_BIN2_LO 14'h0100
`define SSC_BIN2_HI 14'h01FF
`define SSC_BIN3_LO 14'h0200
`define SSC_BIN3_HI 14'h03FF
`define SSC_BIN4_LO 14'h0400
`define SSC_BIN4_HI 14'h05F2
`define SSC_JUMBO_ABOVE 14'h05F3

// ==========================================================
// counter numbers and slots
`define SSC_LAN_FIRST 30
`define SSC_LAN_N 9
`define SSC_SB_N 7
`define SSC_SLOTS 16
`define SSC_FLAGS_N 39
`define SSC_UPPER_USED 7
`define SSC_UPPER_RSVD 25'h000_0000

// ==========================================================
// sideband command and response codes
`define SSC_CMD_CTL_STATS 8'h19
`define SSC_CMD_PT_STATS 8'h1A
`define SSC_RSP_CTL_STATS 8'h99

// ==========================================================
// response payload byte offsets
`define SSC_RSP_FIRST_OFS 6'h14
`define SSC_RSP_LAST_OFS 6'h2F
`define SSC_RSP_CKSUM_OFS 6'h30
`define SSC_RSP_BYTES 5'h1C

`endif

// ===== hdl/ssc_top.v
// sideband statistics counters: lan size bins, cleared bitmap, control stats
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.vh"

module ssc_top #(
    parameter [6:0] SB_SUPPORTED = 7'h7F,   // one bit per control counter 1..7
    parameter FOLD_PFC = 1                   // fold pfc into pause events
) (
    input wire clk,                   // 40 mhz clock
    input wire srst,                  // synchronous reset, active high
    // lan transmit side
    input wire tx_done,               // frame transmitted, one-cycle pulse
    input wire [13:0] tx_len,         // frame length, da through fcs
    input wire tx_good,               // frame was good
    input wire tx_addr_pass,          // frame passed address filtering
    // lan receive side
    input wire rx_done,               // frame received, one-cycle pulse
    input wire [13:0] rx_len,         // frame length, da through fcs
    input wire rx_err_any,            // frame showed some error
    input wire rx_fcs_bad,            // frame fcs was bad
    input wire [13:0] mtu_size,       // programmed mtu size
    // flow control events, bits: rx xon, rx xoff, tx xon, tx xoff
    input wire [3:0] pause_evt,       // plain pause frame events
    input wire [3:0] pfc_evt,         // priority flow control frame events
    output reg [3:0] pause_cnt_evt,   // events for the pause counters
    // outside clears and sideband read of the lan counters
    input wire [29:0] ext_clr_lo,     // counters 0..29 cleared from outside
    input wire [8:0] ext_clr_lan,     // counters 30..38 cleared from outside
    input wire stat_rd,               // sideband read of packet stats, pulse
    input wire [3:0] lan_rd_sel,      // lan counter slot 0..8 = counter 30..38
    output reg [31:0] lan_rd_data,    // selected lan counter, one cycle later
    output reg [31:0] lower_cleared_bits, // cleared flags 0..31 at last read
    output reg [31:0] upper_cleared_bits, // cleared flags 32..38 at last read
    // sideband control packet events, one-cycle pulses
    input wire ctl_init,              // channel enters initial state
    input wire ctl_rx_cmd,            // packet accepted as a command
    input wire ctl_rx_drop,           // packet with good fcs/ethertype dropped
    input wire ctl_drop_chan,         // qualifies drop: bad channel id
    input wire ctl_drop_cksum,        // qualifies drop: bad checksum
    input wire cksum_check_en,        // channel checks command checksums
    input wire ctl_unsup,             // command answered command-unsupported
    input wire ctl_tx_resp,           // response packet sent
    input wire ctl_tx_aen,            // async event notification sent
    // control statistics request and response payload stream
    input wire sb_req,                // command received, one-cycle pulse
    input wire [7:0] sb_cmd,          // command code with sb_req
    output reg sb_busy,               // response payload in progress
    output reg [7:0] rsp_type,        // response type while streaming
    output reg rsp_valid,             // payload byte valid
    output reg [7:0] rsp_data,        // payload byte
    output reg [5:0] rsp_ofs,         // byte offset in the packet
    output reg rsp_last               // last counter byte
);

    // ==========================================================
    // helpers
    function in_range;
        input [13:0] len;
        input [13:0] lo;
        input [13:0] hi;
        begin
            in_range = (len >= lo) && (len <= hi);
        end
    endfunction

    // ==========================================================
    // state encoding
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SEND = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [4:0] byte_left;
    reg [223:0] shift;
    reg [38:0] cleared;

    wire [31:0] count_w [0:15];
    wire [13:0] inc_w [0:15];
    wire [15:0] clr_w;
    wire tx_ok;
    wire rx_ok;
    wire req_take;
    wire sb_clr;
    wire drop_counted;
    wire [1:0] rx_total_inc;
    wire [1:0] tx_total_inc;
    wire [38:0] ext_clr_all;
    wire [223:0] snap;

    // ==========================================================
    // lan counter events
    assign tx_ok = tx_done & tx_good;
    assign rx_ok = rx_done & ~rx_err_any;

    assign inc_w[0] = {13'h0000, tx_ok & in_range(tx_len, `SSC_BIN0_LO, `SSC_BIN0_HI)};
    assign inc_w[1] = {13'h0000, tx_ok & in_range(tx_len, `SSC_BIN1_LO, `SSC_BIN1_HI)};
    assign inc_w[2] = {13'h0000, tx_ok & in_range(tx_len, `SSC_BIN2_LO, `SSC_BIN2_HI)};
    assign inc_w[3] = {13'h0000, tx_ok & in_range(tx_len, `SSC_BIN3_LO, `SSC_BIN3_HI)};
    assign inc_w[4] = {13'h0000, tx_ok & in_range(tx_len, `SSC_BIN4_LO, `SSC_BIN4_HI)};
    // strictly above 1523; a 1523-byte frame lands in no transmit bin
    assign inc_w[5] = {13'h0000, tx_done & tx_addr_pass & (tx_len > `SSC_JUMBO_ABOVE)};
    assign inc_w[6] = rx_ok ? rx_len : 14'h0000;
    assign inc_w[7] = {13'h0000, rx_done & rx_err_any & (rx_len < `SSC_LEN_MIN)};
    assign inc_w[8] = {13'h0000, rx_done & rx_fcs_bad & (rx_len > mtu_size)};

    // ==========================================================
    // sideband control counter events
    // channel-id drops are left out of the drop count
    assign drop_counted = ctl_rx_drop & ~ctl_drop_chan;
    assign rx_total_inc = {1'b0, ctl_rx_cmd} + {1'b0, drop_counted};
    assign tx_total_inc = {1'b0, ctl_tx_resp} + {1'b0, ctl_tx_aen};

    assign inc_w[9] = {13'h0000, ctl_rx_cmd};
    assign inc_w[10] = {13'h0000, drop_counted};
    assign inc_w[11] = {13'h0000, ctl_unsup};
    assign inc_w[12] = {13'h0000, ctl_rx_drop & ctl_drop_cksum & cksum_check_en};
    assign inc_w[13] = {12'h000, rx_total_inc};
    assign inc_w[14] = {12'h000, tx_total_inc};
    assign inc_w[15] = {13'h0000, ctl_tx_aen};

    // ==========================================================
    // clears
    // only the 0x19 request is served here; 0x1A belongs to the pass-through block
    assign req_take = sb_req & (sb_cmd == `SSC_CMD_CTL_STATS) & state[0];
    // cleared in the same cycle as the snapshot, so no event slips between
    assign sb_clr = ctl_init | req_take;

    assign clr_w[8:0] = ext_clr_lan;
    assign clr_w[15:9] = {7{sb_clr}};

    genvar gi;
    generate
        for (gi = 0; gi < `SSC_SLOTS; gi = gi + 1) begin : g_cnt
            ssc_counter u_cnt (
                .clk(clk),
                .srst(srst),
                .clr(clr_w[gi]),
                .inc(inc_w[gi]),
                .count(count_w[gi])
            );
        end
    endgenerate

    // ==========================================================
    // response snapshot, first counter in the top byte
    generate
        for (gi = 0; gi < `SSC_SB_N; gi = gi + 1) begin : g_snap
            // unsupported slots always read as all ones
            assign snap[223 - 32 * gi -: 32] = SB_SUPPORTED[gi] ?
                count_w[9 + gi] : `SSC_CNT_ONES;
        end
    endgenerate

    // ==========================================================
    // response state machine
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_take) begin
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (byte_left == 5'h01) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            byte_left <= 5'h00;
            shift <= {224{1'b0}};
            sb_busy <= 1'b0;
            rsp_type <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_ofs <= 6'h00;
            rsp_last <= 1'b0;
        end else begin
            state <= next_state;
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_take) begin
                        shift <= snap;
                        byte_left <= `SSC_RSP_BYTES;
                        sb_busy <= 1'b1;
                        rsp_type <= `SSC_RSP_CTL_STATS;
                        rsp_ofs <= `SSC_RSP_FIRST_OFS - 6'h01;
                    end
                end
                ST_SEND: begin
                    // most significant byte first at rising offsets
                    rsp_valid <= 1'b1;
                    rsp_data <= shift[223:216];
                    shift <= {shift[215:0], 8'h00};
                    rsp_ofs <= rsp_ofs + 6'h01;
                    byte_left <= byte_left - 5'h01;
                    rsp_last <= (byte_left == 5'h01);
                    if (byte_left == 5'h01) begin
                        sb_busy <= 1'b0;
                    end
                end
                default: begin
                    sb_busy <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // cleared-since-last-read flags
    assign ext_clr_all = {ext_clr_lan, ext_clr_lo};

    always @(posedge clk) begin
        if (srst) begin
            cleared <= {39{1'b0}};
            lower_cleared_bits <= 32'h0000_0000;
            upper_cleared_bits <= 32'h0000_0000;
        end else begin
            // a clear arriving with the read survives into the next read
            cleared <= (cleared & {39{~stat_rd}}) | ext_clr_all;
            if (stat_rd) begin
                lower_cleared_bits <= cleared[31:0];
                upper_cleared_bits <= {`SSC_UPPER_RSVD, cleared[38:32]};
            end
        end
    end

    // ==========================================================
    // lan counter read port
    always @(posedge clk) begin
        if (srst) begin
            lan_rd_data <= 32'h0000_0000;
        end else if (lan_rd_sel < 4'h9) begin
            lan_rd_data <= count_w[lan_rd_sel];
        end else begin
            lan_rd_data <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // flow control event merge
    always @(posedge clk) begin
        if (srst) begin
            pause_cnt_evt <= 4'h0;
        end else if (FOLD_PFC != 0) begin
            pause_cnt_evt <= pause_evt | pfc_evt;
        end else begin
            pause_cnt_evt <= pause_evt;
        end
    end

endmodule
`default_nettype wire

// ===== verif/ssc_chk.sv
// checker for response stream, cleared flags and pause folding
`timescale 1ns/1ps
`default_nettype none
module ssc_chk (
    input wire clk,                       // clock
    input wire srst,                      // synchronous reset
    input wire sb_req,                    // request pulse
    input wire [7:0] sb_cmd,              // command code
    input wire sb_busy,                   // response in progress
    input wire [7:0] rsp_type,            // response type
    input wire rsp_valid,                 // payload byte valid
    input wire [5:0] rsp_ofs,             // byte offset
    input wire rsp_last,                  // last counter byte
    input wire stat_rd,                   // flag read pulse
    input wire [8:0] ext_clr_lan,         // outside clears 30..38
    input wire [31:0] upper_cleared_bits, // flags 32..38
    input wire [3:0] pause_evt,           // pause events
    input wire [3:0] pfc_evt,             // pfc events
    input wire [3:0] pause_cnt_evt        // folded events
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ====
    // properties
    sequence take_s;
        sb_req && sb_cmd == 8'h19 && !sb_busy;
    endsequence
    start_seq_a: assert property (take_s |=> sb_busy && rsp_type == 8'h99
        ##1 rsp_valid && rsp_ofs == 6'h14) else $error("response start wrong");
    resp_len_a: assert property (take_s |-> ##29 rsp_last) else $error("response length wrong");
    last_byte_a: assert property (rsp_last |-> rsp_ofs == 6'h2F && !sb_busy)
        else $error("last byte offset wrong");
    byte_order_a: assert property (rsp_valid && !rsp_last |=> rsp_valid
        && rsp_ofs == $past(rsp_ofs) + 6'h01) else $error("byte stream broken");
    pt_ignored_a: assert property (sb_req && sb_cmd == 8'h1A && !sb_busy
        |=> !sb_busy ##1 !rsp_valid) else $error("pass-through request answered here");
    pause_fold_a: assert property (!$past(srst) |-> pause_cnt_evt == $past(pause_evt | pfc_evt))
        else $error("pause events not folded");
    upper_rsvd_a: assert property (upper_cleared_bits[31:7] == 25'h000_0000)
        else $error("reserved flag bits set");
    clr_read_a: assert property (stat_rd && ext_clr_lan[8:2] == 7'h00 ##1 stat_rd
        |=> upper_cleared_bits[6:0] == 7'h00) else $error("flags survive a read");
    cover property (take_s ##29 rsp_last);
    cover property (stat_rd ##1 stat_rd);
    cover property (sb_req && sb_cmd == 8'h1A);
endmodule
bind ssc_top ssc_chk u_chk (.clk(clk), .srst(srst), .sb_req(sb_req), .sb_cmd(sb_cmd),
    .sb_busy(sb_busy), .rsp_type(rsp_type), .rsp_valid(rsp_valid), .rsp_ofs(rsp_ofs),
    .rsp_last(rsp_last), .stat_rd(stat_rd), .ext_clr_lan(ext_clr_lan),
    .upper_cleared_bits(upper_cleared_bits), .pause_evt(pause_evt), .pfc_evt(pfc_evt),
    .pause_cnt_evt(pause_cnt_evt));
`default_nettype wire

// ===== verif/ssc_mc_model.sv
// management controller model: sends statistics requests, gathers answers
`timescale 1ns/1ps
`default_nettype none
module ssc_mc_model (
    input wire clk,            // clock
    input wire rsp_valid,      // payload byte valid
    input wire [7:0] rsp_data, // payload byte
    input wire [5:0] rsp_ofs,  // byte offset
    output logic sb_req,       // request pulse
    output logic [7:0] sb_cmd  // command code
);
    logic [31:0] word;
    logic [31:0] got_q[$];
    initial begin
        sb_req = 1'b0;
        sb_cmd = 8'h00;
        word = 32'h0000_0000;
    end
    // ====
    // one-cycle request, then a fixed answer window
    task automatic req(input logic [7:0] c);
        @(posedge clk);
        sb_req <= 1'b1;
        sb_cmd <= c;
        @(posedge clk);
        sb_req <= 1'b0;
        sb_cmd <= ~c; // no stale code left on the lines
        repeat (34) @(posedge clk);
    endtask
    // bytes arrive msb first; a word closes at offsets whose two low bits are both set
    always @(posedge clk) begin
        if (rsp_valid) begin
            word = {word[23:0], rsp_data};
            if (rsp_ofs[1:0] == 2'b11) got_q.push_back(word);
        end
    end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the sideband statistics counters
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, srst = 1, tx_done = 0, tx_good = 0, tx_addr_pass = 0, rx_done = 0;
    logic rx_err_any = 0, rx_fcs_bad = 0, stat_rd = 0, ctl_init = 0, ctl_rx_cmd = 0;
    logic ctl_rx_drop = 0, ctl_drop_chan = 0, ctl_drop_cksum = 0, cksum_check_en = 0;
    logic ctl_unsup = 0, ctl_tx_resp = 0, ctl_tx_aen = 0;
    logic [13:0] tx_len = 0, rx_len = 0, mtu_size = 14'h05DC;
    logic [3:0] pause_evt = 0, pfc_evt = 0, lan_rd_sel = 0;
    logic [29:0] ext_clr_lo = 0;
    logic [8:0] ext_clr_lan = 0;
    wire sb_req, sb_busy, rsp_valid, rsp_last;
    wire [7:0] sb_cmd, rsp_type, rsp_data;
    wire [5:0] rsp_ofs;
    wire [3:0] pause_cnt_evt;
    wire [31:0] lan_rd_data, lower_cleared_bits, upper_cleared_bits;
    int miscompares = 0, total_checks = 0, cyc = 0;
    int lan[9], sbc[7];
    int bl[13] = '{64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1522, 1523, 1524};
    logic [38:0] flg;
    logic [31:0] exp_lo, exp_hi;
    logic [31:0] exp_q[$];
    ssc_top dut (.clk(clk), .srst(srst), .tx_done(tx_done), .tx_len(tx_len),
        .tx_good(tx_good), .tx_addr_pass(tx_addr_pass), .rx_done(rx_done), .rx_len(rx_len),
        .rx_err_any(rx_err_any), .rx_fcs_bad(rx_fcs_bad), .mtu_size(mtu_size),
        .pause_evt(pause_evt), .pfc_evt(pfc_evt), .pause_cnt_evt(pause_cnt_evt),
        .ext_clr_lo(ext_clr_lo), .ext_clr_lan(ext_clr_lan), .stat_rd(stat_rd),
        .lan_rd_sel(lan_rd_sel), .lan_rd_data(lan_rd_data),
        .lower_cleared_bits(lower_cleared_bits), .upper_cleared_bits(upper_cleared_bits),
        .ctl_init(ctl_init), .ctl_rx_cmd(ctl_rx_cmd), .ctl_rx_drop(ctl_rx_drop),
        .ctl_drop_chan(ctl_drop_chan), .ctl_drop_cksum(ctl_drop_cksum),
        .cksum_check_en(cksum_check_en), .ctl_unsup(ctl_unsup), .ctl_tx_resp(ctl_tx_resp),
        .ctl_tx_aen(ctl_tx_aen), .sb_req(sb_req), .sb_cmd(sb_cmd), .sb_busy(sb_busy),
        .rsp_type(rsp_type), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ofs(rsp_ofs),
        .rsp_last(rsp_last));
    ssc_mc_model u_mc (.clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ofs(rsp_ofs), .sb_req(sb_req), .sb_cmd(sb_cmd));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ====
    // reference model, sampling the same edges as the design
    always @(posedge clk) begin
        int b;
        if (srst) begin
            foreach (lan[i]) lan[i] = 0;
            foreach (sbc[i]) sbc[i] = 0;
            flg = 0;
            exp_lo = 0;
            exp_hi = 0;
        end else begin
            foreach (lan[i]) if (ext_clr_lan[i]) lan[i] = 0;
            b = tx_len > 1522 ? 9 : tx_len > 1023 ? 4 : tx_len > 511 ? 3 : tx_len > 255 ? 2 :
                tx_len > 127 ? 1 : tx_len > 64 ? 0 : 9;
            if (tx_done && tx_good && b < 9) lan[b]++;
            if (tx_done && tx_addr_pass && tx_len > 1523) lan[5]++;
            if (rx_done && !rx_err_any) lan[6] += rx_len;
            if (rx_done && rx_err_any && rx_len < 64) lan[7]++;
            if (rx_done && rx_fcs_bad && rx_len > mtu_size) lan[8]++;
            if (stat_rd) begin
                exp_lo = flg[31:0];
                exp_hi = {25'h000_0000, flg[38:32]};
                flg = 0;
            end
            flg = flg | {ext_clr_lan, ext_clr_lo};
            if (sb_req && sb_cmd == 8'h19) begin
                foreach (sbc[i]) exp_q.push_back(sbc[i]);
                foreach (sbc[i]) sbc[i] = 0;
            end
            if (ctl_init) foreach (sbc[i]) sbc[i] = 0;
            sbc[0] += ctl_rx_cmd;
            sbc[1] += ctl_rx_drop && !ctl_drop_chan;
            sbc[2] += ctl_unsup;
            sbc[3] += ctl_rx_drop && ctl_drop_cksum && cksum_check_en;
            sbc[4] += ctl_rx_cmd + (ctl_rx_drop && !ctl_drop_chan);
            sbc[5] += ctl_tx_resp + ctl_tx_aen;
            sbc[6] += ctl_tx_aen;
        end
    end
    // ====
    // tasks
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // last pass draws all-zero random words, which idles every pulse
    task automatic traffic(input int n);
        logic [31:0] r, q;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            r = i < n ? $urandom : 32'h0000_0000;
            q = i < n ? $urandom : 32'h0000_0000;
            tx_done <= r[0];
            tx_good <= r[1] | r[2];
            tx_addr_pass <= r[3];
            tx_len <= r[4] ? 14'(bl[r[11:8] % 13]) : 14'($urandom_range(40, 1600));
            rx_done <= r[5];
            rx_len <= 14'($urandom_range(40, 1600));
            rx_err_any <= r[6] & r[7];
            rx_fcs_bad <= r[8] & r[9];
            pause_evt <= r[15:12];
            pfc_evt <= r[19:16];
            ext_clr_lo <= r[24:20] == 5'h1F ? 30'($urandom) : 30'h0000_0000;
            ext_clr_lan <= r[24:20] == 5'h1E ? 9'($urandom) : 9'h000;
            ctl_init <= r[29:25] == 5'h1F;
            q = r[29:25] == 5'h1F ? 32'h0000_0000 : q;
            ctl_rx_cmd <= q[0];
            ctl_rx_drop <= q[1];
            ctl_drop_chan <= q[2] & q[3];
            ctl_drop_cksum <= q[4];
            cksum_check_en <= q[5];
            ctl_unsup <= q[6];
            ctl_tx_resp <= q[7];
            ctl_tx_aen <= q[8];
        end
    endtask
    task automatic rd_lan();
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            lan_rd_sel <= 4'(k);
            @(posedge clk);
            @(negedge clk);
            chk("lan counter", lan_rd_data, lan[k]);
        end
    endtask
    // two reads back to back: the second sees only what the first left set
    task automatic rd_flags();
        @(posedge clk);
        stat_rd <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            stat_rd <= (k == 0);
            @(negedge clk);
            chk("lower flags", lower_cleared_bits, exp_lo);
            chk("upper flags", upper_cleared_bits, exp_hi);
        end
    endtask
    task automatic chk_rsp();
        chk("word count", u_mc.got_q.size(), exp_q.size());
        while (exp_q.size() > 0 && u_mc.got_q.size() > 0)
            chk("response word", u_mc.got_q.pop_front(), exp_q.pop_front());
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    // ====
    // main sequence
    initial begin
        void'($urandom(32'h7b0da9a3));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            mtu_size <= 14'($urandom_range(1400, 1530));
            traffic(400);
            rd_lan();
            rd_flags();
            u_mc.req(8'h19);
            u_mc.req(8'h1A);
            u_mc.req(8'h19);
            chk_rsp();
        end
        conclude();
    end
endmodule
`default_nettype wire
